// ### sim/lsh_link_model.sv
/*
  Model of the linked units: run and error levels on the controller pins.
  Assumes the bench sets the wanted states; pins move on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none

module lsh_link_model (
  // Clock.
  input wire logic clk_i,
  // Wanted unit states.
  input wire logic [31:0] run_req_i,
  input wire logic [31:0] err_req_i,
  input wire logic multi_req_i,
  // Pins toward the controller.
  output logic [31:0] unit_run_o,
  output logic [31:0] unit_err_o,
  output logic multilevel_o
);
  // Units are not clocked by the controller, so levels change away from its sampling edge.
  always @(negedge clk_i) begin
    unit_run_o <= run_req_i;
    unit_err_o <= err_req_i;
    multilevel_o <= multi_req_i;
  end
endmodule // lsh_link_model

`default_nettype wire

// ### sim/lsh_top_monitor.sv
/*
  Checker for lsh_top: bus handshake, relay-area pulses and hold bits.
  Assumes it is bound to lsh_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module lsh_top_monitor (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Sequencing and effects.
  input wire logic [1:0] op_mode_i,
  input wire logic prog_set_io_hold_i,
  input wire logic power_restore_i,
  input wire logic io_table_registered_i,
  input wire logic force_default_o,
  input wire logic io_relay_reset_o,
  input wire logic forced_state_retention_bit_o,
  input wire logic io_state_retention_bit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dat_zero_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data not zero");
  a_run_entry_default: assert property ($changed(op_mode_i) && op_mode_i == 2'h2
    |=> force_default_o)
    else $error("no default into run");
  a_force_clear_default: assert property ($changed(op_mode_i)
    && !forced_state_retention_bit_o |=> force_default_o)
    else $error("no force default");
  a_io_clear_reset: assert property (!io_state_retention_bit_o
    && ((op_mode_i == 2'h0) != ($past(op_mode_i) == 2'h0)) |=> io_relay_reset_o)
    else $error("no relay reset");
  a_quiet_no_default: assert property (!$changed(op_mode_i) && !power_restore_i
    |=> !force_default_o)
    else $error("stray default");
  a_power_default: assert property (power_restore_i && !forced_state_retention_bit_o
    |=> force_default_o)
    else $error("no default on power");
  a_table_clears_hold: assert property (power_restore_i && io_table_registered_i
    |=> !forced_state_retention_bit_o)
    else $error("hold kept");
  a_prog_sets_hold: assert property (prog_set_io_hold_i && !power_restore_i
    |=> io_state_retention_bit_o)
    else $error("hold not set");

  c_bus_write: cover property (wb_ack_o && wb_we_i);
  c_force_pulse: cover property (force_default_o);
  c_io_pulse: cover property (io_relay_reset_o);
endmodule // lsh_top_monitor

bind lsh_top lsh_top_monitor mon_u (.clk_i, .srst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_dat_o, .wb_ack_o, .op_mode_i, .prog_set_io_hold_i, .power_restore_i,
  .io_table_registered_i, .force_default_o, .io_relay_reset_o,
  .forced_state_retention_bit_o, .io_state_retention_bit_o);

`default_nettype wire

// ### sim/lsh_top_tb.sv
/*
  Self-checking bench for lsh_top: status words, hold bits, events.
  Assumes the link model drives the unit pins and the monitor is bound.
*/
`timescale 1ns/100ps
`default_nettype none

module lsh_top_tb;
  logic clk_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, multilevel_i, ml_req, irq_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, unit_run_i, unit_err_i, run_req, err_req, q;
  logic [1:0] op_mode_i;
  logic sys_inst_force_en_i, sys_inst_io_en_i, sys_inst_at_step0_i, prog_set_io_hold_i;
  logic prog_clr_io_hold_i, power_restore_i, io_table_registered_i, force_default_o;
  logic io_relay_reset_o, forced_state_retention_bit_o, io_state_retention_bit_o;
  int fail_count, checked;

  lsh_top dut_u (.clk_i, .srst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .unit_run_i, .unit_err_i, .multilevel_i, .op_mode_i,
    .sys_inst_force_en_i, .sys_inst_io_en_i, .sys_inst_at_step0_i, .prog_set_io_hold_i,
    .prog_clr_io_hold_i, .power_restore_i, .io_table_registered_i, .force_default_o,
    .io_relay_reset_o, .forced_state_retention_bit_o, .io_state_retention_bit_o, .irq_o);
  lsh_link_model units_u (.clk_i, .run_req_i(run_req), .err_req_i(err_req),
    .multi_req_i(ml_req), .unit_run_o(unit_run_i), .unit_err_o(unit_err_i),
    .multilevel_o(multilevel_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The master waits for ack itself; the bound only guards against a hung slave.
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      finish_test();
    end else begin
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task automatic t_status(input logic [31:0] r, input logic [31:0] e, input logic m);
    run_req <= r;
    err_req <= e;
    ml_req <= m;
    repeat (5) @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      wb(1'b0, 8'(lsh_pkg::LSH_IDX_STAT_D - k), 32'h0);
      chk(q, {16'h0, e[8*k +: 8], r[8*k +: 8]});
    end
    wb(1'b0, lsh_pkg::LSH_IDX_STATE, 32'h0);
    chk({31'h0, q[5]}, {31'h0, m});
  endtask

  task automatic t_mode(input logic [1:0] m, input logic [1:0] exp);
    op_mode_i <= m;
    repeat (2) @(posedge clk_i);
    chk({30'h0, force_default_o, io_relay_reset_o}, {30'h0, exp});
    @(posedge clk_i);
  endtask

  task automatic t_enable();
    sys_inst_force_en_i <= 1'b1;
    sys_inst_io_en_i <= 1'b1;
    sys_inst_at_step0_i <= 1'b1;
    @(posedge clk_i);
    sys_inst_force_en_i <= 1'b0;
    sys_inst_io_en_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic t_pwr(input logic tbl, input logic [1:0] exp);
    io_table_registered_i <= tbl;
    power_restore_i <= 1'b1;
    @(posedge clk_i);
    power_restore_i <= 1'b0;
    @(posedge clk_i);
    chk({30'h0, force_default_o, forced_state_retention_bit_o}, {30'h0, exp});
    @(posedge clk_i);
  endtask

  task automatic sc_bus();
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, lsh_pkg::LSH_IDX_CTRL, 32'h3);
    wb(1'b0, lsh_pkg::LSH_IDX_CTRL, 32'h0);
    chk(q, 32'h3);
    wb_sel_i <= 4'hE;
    wb(1'b1, lsh_pkg::LSH_IDX_CTRL, 32'h0);
    wb_sel_i <= 4'hF;
    wb(1'b0, lsh_pkg::LSH_IDX_CTRL, 32'h0);
    chk(q, 32'h3);
  endtask

  task automatic sc_hold();
    t_mode(2'h1, 2'h3);
    t_mode(2'h0, 2'h3);
    t_enable();
    t_mode(2'h1, 2'h0);
    t_mode(2'h2, 2'h2);
    t_mode(2'h0, 2'h0);
    wb(1'b1, lsh_pkg::LSH_IDX_CTRL, 32'h0);
    t_mode(2'h1, 2'h3);
    t_mode(2'h0, 2'h3);
  endtask

  task automatic sc_irq();
    wb(1'b1, lsh_pkg::LSH_IDX_EVT, 32'hF);
    wb(1'b1, lsh_pkg::LSH_IDX_MASK, 32'h4);
    chk({31'h0, irq_o}, 32'h0);
    t_mode(2'h2, 2'h3);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, lsh_pkg::LSH_IDX_EVT, 32'h4);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, lsh_pkg::LSH_IDX_MASK, 32'h0);
    t_mode(2'h0, 2'h3);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b0, lsh_pkg::LSH_IDX_EVT, 32'h0);
    chk(q, 32'hC);
    wb(1'b1, lsh_pkg::LSH_IDX_EVT, 32'hF);
  endtask

  task automatic sc_prog();
    prog_set_io_hold_i <= 1'b1;
    @(posedge clk_i);
    prog_set_io_hold_i <= 1'b0;
    wb(1'b0, lsh_pkg::LSH_IDX_CTRL, 32'h0);
    chk(q, 32'h2);
    chk({31'h0, io_state_retention_bit_o}, 32'h1);
    prog_clr_io_hold_i <= 1'b1;
    @(posedge clk_i);
    prog_clr_io_hold_i <= 1'b0;
    wb(1'b0, lsh_pkg::LSH_IDX_CTRL, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, io_state_retention_bit_o}, 32'h0);
  endtask

  task automatic sc_power();
    wb(1'b1, lsh_pkg::LSH_IDX_CTRL, 32'h1);
    t_enable();
    t_pwr(1'b0, 2'h1);
    t_pwr(1'b0, 2'h2);
    wb(1'b1, lsh_pkg::LSH_IDX_CTRL, 32'h1);
    t_enable();
    t_pwr(1'b1, 2'h2);
  endtask

  initial begin
    fail_count = 0;
    checked = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, run_req, err_req, ml_req} = '0;
    {op_mode_i, sys_inst_force_en_i, sys_inst_io_en_i, sys_inst_at_step0_i} = '0;
    {prog_set_io_hold_i, prog_clr_io_hold_i, power_restore_i, io_table_registered_i} = '0;
    wb_sel_i = 4'hF;
    srst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    t_status(32'h8001_7E01, 32'h0180_0102, 1'b0);
    t_status(32'hC3FF_A55A, 32'h3C02_0F81, 1'b1);
    sc_bus();
    sc_hold();
    sc_irq();
    sc_prog();
    sc_power();
    finish_test();
  end
endmodule // lsh_top_tb

`default_nettype wire

// ### verilog/lsh_irq.sv
/*
  Sticky event flags with write-one-to-clear, a mask and one level interrupt.
  Assumes set pulses and clear strobes come from the clk_i domain.
*/
`timescale 1ns/100ps
`default_nettype none

module lsh_irq #(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Events and software access.
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  input wire logic mask_we_i,
  input wire logic [WIDTH-1:0] mask_i,
  // State.
  output logic [WIDTH-1:0] flag_o,
  output logic [WIDTH-1:0] mask_o,
  output logic irq_o
);

  logic [WIDTH-1:0] flag_nxt;

  // A set arriving with its own clear wins, so no event is lost.
  assign flag_nxt = (flag_o & ~clr_i) | set_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_o <= lsh_pkg::LSH_EVT_RESET;
      mask_o <= lsh_pkg::LSH_MASK_RESET;
      irq_o <= 1'b0;
    end else begin
      flag_o <= flag_nxt;
      if (mask_we_i) begin
        mask_o <= mask_i;
      end
      irq_o <= |(flag_nxt & (mask_we_i ? mask_i : mask_o));
    end
  end

endmodule // lsh_irq

`default_nettype wire

// ### verilog/lsh_pkg.sv
/*
  Constants of the link status and hold bit bank: register indices, field
  positions, reset values and the synchroniser depth.
  Assumes a 32-bit classic Wishbone bus whose byte address is four times
  the register index.
*/
`default_nettype none

package lsh_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] LSH_IDX_STAT_A = 8'hF7;
  localparam logic [7:0] LSH_IDX_STAT_B = 8'hF8;
  localparam logic [7:0] LSH_IDX_STAT_C = 8'hF9;
  localparam logic [7:0] LSH_IDX_STAT_D = 8'hFA;
  localparam logic [7:0] LSH_IDX_CTRL = 8'hFB;
  localparam logic [7:0] LSH_IDX_EVT = 8'hFC;
  localparam logic [7:0] LSH_IDX_MASK = 8'hFD;
  localparam logic [7:0] LSH_IDX_STATE = 8'hFE;

  // Control register fields.
  localparam int LSH_CTRL_FORCE_HOLD = 0;
  localparam int LSH_CTRL_IO_HOLD = 1;
  localparam logic [1:0] LSH_CTRL_RESET = 2'h0;

  // Event register fields.
  localparam int LSH_EVT_W = 4;
  localparam int LSH_EVT_RUN_CHG = 0;
  localparam int LSH_EVT_ERR_SET = 1;
  localparam int LSH_EVT_FORCE_DEF = 2;
  localparam int LSH_EVT_IO_CLR = 3;
  localparam logic [3:0] LSH_EVT_RESET = 4'h0;
  localparam logic [3:0] LSH_MASK_RESET = 4'h0;

  // State register fields.
  localparam int LSH_ST_MODE_LSB = 0;
  localparam int LSH_ST_FORCE_EN = 2;
  localparam int LSH_ST_IO_EN = 3;
  localparam int LSH_ST_STEP0 = 4;
  localparam int LSH_ST_MULTI = 5;

  // Units and word layout.
  localparam int LSH_UNITS = 32;
  localparam int LSH_UNITS_PER_WORD = 8;
  localparam int LSH_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    LSH_MODE_PROGRAM,
    LSH_MODE_MONITOR,
    LSH_MODE_RUN
  } lsh_mode_t;

endpackage

`default_nettype wire

// ### verilog/lsh_sync.sv
/*
  Two flip-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/100ps
`default_nettype none

module lsh_sync #(
  parameter int WIDTH = 32
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Levels.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // lsh_sync

`default_nettype wire

// ### verilog/lsh_top.sv
/*
  Link unit status words and the two retention-control bits of the
  controller, reached over a classic Wishbone slave with 32-bit data.
  Assumes unit run and error levels arrive asynchronously on pins, and that
  mode, instruction and power-sequence strobes come from clk_i logic.
*/
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Four consecutive status words report the state of up to 32 link units.
// - Low eight bits of each word are run flags, set while unit runs.
// - High eight bits of each word are error flags, set on unit error.
// - Single-level: last word units 0-7, then 8-15, 16-23, first 24-31.
// - Multilevel: last two words level 0, first two words level 1.
// - In two-level systems half the units are level 0, half level 1.
// - Forced-state hold set keeps forced bits across program/monitor switches.
// - Forced-state hold acts only once the system-setting instruction enabled it.
// - Power loss clears forced-state hold unless set at step zero and the I/O table is not registered.
// - Entering run mode always returns forced bits to default.
// - Hold survives power-off only with system-setting instruction at step zero.
// - I/O hold set keeps I/O and link relay bits on start or stop.
// - I/O hold acts only once the system-setting instruction enabled it.
// - I/O hold is set by program output instruction or peripheral write.
module lsh_top (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link unit pins, asynchronous.
  input wire logic [31:0] unit_run_i,
  input wire logic [31:0] unit_err_i,
  input wire logic multilevel_i,
  // Controller sequencing, same clock.
  input wire logic [1:0] op_mode_i,
  input wire logic sys_inst_force_en_i,
  input wire logic sys_inst_io_en_i,
  input wire logic sys_inst_at_step0_i,
  input wire logic prog_set_io_hold_i,
  input wire logic prog_clr_io_hold_i,
  input wire logic power_restore_i,
  input wire logic io_table_registered_i,
  // Effects on the relay areas.
  output logic force_default_o,
  output logic io_relay_reset_o,
  output logic forced_state_retention_bit_o,
  output logic io_state_retention_bit_o,
  output logic irq_o
);

  localparam int EW = lsh_pkg::LSH_EVT_W;

  // Assembles one status word: run flags low, error flags high.
  function automatic logic [15:0] pack_word(input logic [31:0] run,
                                            input logic [31:0] err,
                                            input int base);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < lsh_pkg::LSH_UNITS_PER_WORD; i++) begin
      w[i] = run[base + i];
      w[i + 8] = err[base + i];
    end
    return w;
  endfunction

  // Tells whether a mode value is program mode.
  function automatic logic is_program(input logic [1:0] m);
    return m == lsh_pkg::LSH_MODE_PROGRAM;
  endfunction

  // Synchronised pin levels.
  logic [31:0] run_s;
  logic [31:0] err_s;
  logic multi_s;

  // Edge history.
  logic [31:0] run_prev_r;
  logic [31:0] err_prev_r;
  logic [1:0] mode_prev_r;

  // Retention bits and the instruction enables that arm them.
  logic force_hold_r;
  logic force_hold_nxt;
  logic io_hold_r;
  logic io_hold_nxt;
  logic force_en_r;
  logic io_en_r;
  logic step0_r;

  // Event block.
  logic [EW-1:0] evt_flag;
  logic [EW-1:0] evt_mask;
  logic irq_w;

  lsh_sync #(
    .WIDTH(65)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i({multilevel_i, unit_err_i, unit_run_i}),
    .sync_o({multi_s, err_s, run_s})
  );

  // Word mapping. In multilevel systems pins 0-15 carry level-0 units 0-15 and
  // pins 16-31 carry level-1 units 0-15, so both layouts land on the same
  // bit slices; the level only changes how software names the units.
  wire [15:0] word_d = pack_word(run_s, err_s, 0);
  wire [15:0] word_c = pack_word(run_s, err_s, 8);
  wire [15:0] word_b = pack_word(run_s, err_s, 16);
  wire [15:0] word_a = pack_word(run_s, err_s, 24);

  // Bus decode. A write lands at the edge that takes the request, the same edge
  // that raises ack; all fields sit in byte 0, so a write without sel[0] is dropped.
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0] idx = wb_adr_i[9:2];
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire sel_ctrl = idx == lsh_pkg::LSH_IDX_CTRL;
  wire sel_evt = idx == lsh_pkg::LSH_IDX_EVT;
  wire sel_mask = idx == lsh_pkg::LSH_IDX_MASK;
  wire wr_ctrl = bus_wr & sel_ctrl;
  wire wr_evt = bus_wr & sel_evt;
  wire wr_mask = bus_wr & sel_mask;
  wire sel_stat_a = idx == lsh_pkg::LSH_IDX_STAT_A;
  wire sel_stat_b = idx == lsh_pkg::LSH_IDX_STAT_B;
  wire sel_stat_c = idx == lsh_pkg::LSH_IDX_STAT_C;
  wire sel_stat_d = idx == lsh_pkg::LSH_IDX_STAT_D;
  wire sel_state = idx == lsh_pkg::LSH_IDX_STATE;

  wire [5:0] state_word = {multi_s, step0_r, io_en_r, force_en_r, mode_prev_r};

  // Read mux. Status words sit in the low half; the upper half and every
  // unmapped index read as zero, so software can probe the bank safely.
  logic [31:0] rd_data;
  always_comb begin
    if (sel_stat_a) begin
      rd_data = {16'h0000, word_a};
    end else if (sel_stat_b) begin
      rd_data = {16'h0000, word_b};
    end else if (sel_stat_c) begin
      rd_data = {16'h0000, word_c};
    end else if (sel_stat_d) begin
      rd_data = {16'h0000, word_d};
    end else if (sel_ctrl) begin
      rd_data = {30'h00000000, io_hold_r, force_hold_r};
    end else if (sel_evt) begin
      rd_data = {28'h0000000, evt_flag};
    end else if (sel_mask) begin
      rd_data = {28'h0000000, evt_mask};
    end else if (sel_state) begin
      rd_data = {26'h0000000, state_word};
    end else begin
      rd_data = 32'h00000000;
    end
  end

  // Mode transitions.
  wire [1:0] mode_now = op_mode_i;
  wire mode_chg = mode_now != mode_prev_r;
  wire to_run = mode_chg & (mode_now == lsh_pkg::LSH_MODE_RUN);
  wire mode_is_prog = is_program(mode_now);
  wire mode_was_prog = is_program(mode_prev_r);
  wire start_stop = mode_chg & (mode_is_prog != mode_was_prog);
  wire force_kept = force_hold_r & force_en_r;
  wire io_kept = io_hold_r & io_en_r;

  // Run entry overrides the hold bit entirely.
  wire force_def_mode = to_run | (mode_chg & ~force_kept);
  wire io_reset_mode = start_stop & ~io_kept;

  // Power restore: a bit survives only when the setting instruction stood at
  // step zero; registering the I/O table clears the forced-state bit.
  wire force_pwr_keep = step0_r & force_hold_r & ~io_table_registered_i;
  wire io_pwr_keep = step0_r & io_hold_r;
  wire force_def_pwr = power_restore_i & ~force_pwr_keep;
  wire io_reset_pwr = power_restore_i & ~io_pwr_keep;

  always_comb begin
    force_hold_nxt = force_hold_r;
    if (wr_ctrl) begin
      force_hold_nxt = wb_dat_i[lsh_pkg::LSH_CTRL_FORCE_HOLD];
    end
    if (power_restore_i && !force_pwr_keep) begin
      force_hold_nxt = 1'b0;
    end
  end

  // Program set beats a bus write, which beats a program clear; a power
  // restore that does not keep the bit clears it last.
  always_comb begin
    io_hold_nxt = io_hold_r;
    if (prog_clr_io_hold_i) begin
      io_hold_nxt = 1'b0;
    end
    if (wr_ctrl) begin
      io_hold_nxt = wb_dat_i[lsh_pkg::LSH_CTRL_IO_HOLD];
    end
    if (prog_set_io_hold_i) begin
      io_hold_nxt = 1'b1;
    end
    if (power_restore_i && !io_pwr_keep) begin
      io_hold_nxt = 1'b0;
    end
  end

  // Event sources. Run flags report any change, error flags only a rise, since
  // an error that goes away needs no attention.
  wire run_chg = |(run_s ^ run_prev_r);
  wire err_rise = |(err_s & ~err_prev_r);
  wire [EW-1:0] evt_set;
  assign evt_set[lsh_pkg::LSH_EVT_RUN_CHG] = run_chg;
  assign evt_set[lsh_pkg::LSH_EVT_ERR_SET] = err_rise;
  assign evt_set[lsh_pkg::LSH_EVT_FORCE_DEF] = force_def_mode | force_def_pwr;
  assign evt_set[lsh_pkg::LSH_EVT_IO_CLR] = io_reset_mode | io_reset_pwr;

  wire [EW-1:0] evt_clr = wr_evt ? wb_dat_i[EW-1:0] : '0;

  lsh_irq #(
    .WIDTH(EW)
  ) u_irq (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .set_i(evt_set),
    .clr_i(evt_clr),
    .mask_we_i(wr_mask),
    .mask_i(wb_dat_i[EW-1:0]),
    .flag_o(evt_flag),
    .mask_o(evt_mask),
    .irq_o(irq_w)
  );

  // Bus answer: one wait cycle, unmapped reads give zero. The data register is
  // cleared between answers so a stale word never sits on the bus.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= bus_req ? rd_data : 32'h00000000;
    end
  end

  // Instruction enables. They are volatile: the setting instruction must run
  // again after every power restore before either hold bit acts again.
  wire sys_inst_seen = sys_inst_force_en_i | sys_inst_io_en_i;
  wire step0_mark = sys_inst_seen & sys_inst_at_step0_i;
  wire force_en_nxt = ~power_restore_i & (force_en_r | sys_inst_force_en_i);
  wire io_en_nxt = ~power_restore_i & (io_en_r | sys_inst_io_en_i);
  wire step0_nxt = ~power_restore_i & (step0_r | step0_mark);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      force_en_r <= 1'b0;
      io_en_r <= 1'b0;
      step0_r <= 1'b0;
    end else begin
      force_en_r <= force_en_nxt;
      io_en_r <= io_en_nxt;
      step0_r <= step0_nxt;
    end
  end

  // Retention bits.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      force_hold_r <= lsh_pkg::LSH_CTRL_RESET[lsh_pkg::LSH_CTRL_FORCE_HOLD];
    end else begin
      force_hold_r <= force_hold_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      io_hold_r <= lsh_pkg::LSH_CTRL_RESET[lsh_pkg::LSH_CTRL_IO_HOLD];
    end else begin
      io_hold_r <= io_hold_nxt;
    end
  end

  // Edge history. Mode history starts at program so that leaving reset in
  // program mode is not seen as a mode change.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_prev_r <= lsh_pkg::LSH_MODE_PROGRAM;
      run_prev_r <= 32'h00000000;
      err_prev_r <= 32'h00000000;
    end else begin
      mode_prev_r <= mode_now;
      run_prev_r <= run_s;
      err_prev_r <= err_s;
    end
  end

  // Pulses to the relay areas.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      force_default_o <= 1'b0;
      io_relay_reset_o <= 1'b0;
    end else begin
      force_default_o <= force_def_mode | force_def_pwr;
      io_relay_reset_o <= io_reset_mode | io_reset_pwr;
    end
  end

  // Mirrors of the retention bits take the next value, so the pins and the
  // control register agree in every cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      forced_state_retention_bit_o <= 1'b0;
      io_state_retention_bit_o <= 1'b0;
    end else begin
      forced_state_retention_bit_o <= force_hold_nxt;
      io_state_retention_bit_o <= io_hold_nxt;
    end
  end

  // The event block already registers its interrupt; this stage only keeps
  // every top-level output on a flip-flop of its own.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_w;
    end
  end

endmodule // lsh_top

`default_nettype wire
